// >>> lbac_pkg.sv
// lbac_pkg: shared constants for the local bus address-cycle pins
package lbac_pkg;
    localparam int ADDR_W = 32;
    localparam int CODE_W = 4;
    localparam int SIZE_W = 2;
    localparam int REG_OFF_W = 12;
    localparam logic [3:0] CODE_DMA = 4'hf;
    localparam logic [31:0] ADDR_RST = 32'h0000_0000;
    localparam logic [3:0] CODE_RST = 4'h0;
    localparam logic [1:0] SIZE_RST = 2'h0;
    localparam logic [11:0] OFF_RST = 12'h000;
    // size encoding: byte count of the cycle, 0 means four bytes
    localparam logic [1:0] SIZE_LONG = 2'h0;
    localparam logic [1:0] SIZE_BYTE = 2'h1;
    localparam logic [1:0] SIZE_HALF = 2'h2;
    localparam logic [1:0] SIZE_TRI = 2'h3;
endpackage

// >>> lbac_if.sv
// lbac_if: address, size, code and strobe wires between the two ends
`timescale 1ns/10ps
interface lbac_if;
    logic [31:0] addrDev;
    logic [31:0] addrPeer;
    logic addrDevOe_n;
    logic addrPeerOe_n;
    logic [1:0] transferByteCountDev;
    logic [1:0] transferByteCountPeer;
    logic [3:0] transactionCodeLinesDev;
    logic [3:0] transactionCodeLinesPeer;
    logic transferStartDev_n;
    logic transferStartPeer_n;
    logic addressStrobeDev_n;
    logic addressStrobePeer_n;
    logic dmaAcknowledge_n;
    // resolved wire levels; an undriven bus reads as all ones (pull-ups)
    logic [31:0] addr;
    logic [1:0] transferByteCount;
    logic [3:0] transactionCodeLines;
    logic transferStart_n;
    logic addressStrobe_n;
    assign addr = !addrDevOe_n ? addrDev : (!addrPeerOe_n ? addrPeer : 32'hffff_ffff);
    assign transferByteCount = !addrDevOe_n ? transferByteCountDev
        : (!addrPeerOe_n ? transferByteCountPeer : 2'h3);
    assign transactionCodeLines = !addrDevOe_n ? transactionCodeLinesDev
        : (!addrPeerOe_n ? transactionCodeLinesPeer : 4'hf);
    assign transferStart_n = !addrDevOe_n ? transferStartDev_n : (!addrPeerOe_n ? transferStartPeer_n : 1'b1);
    assign addressStrobe_n = !addrDevOe_n ? addressStrobeDev_n : (!addrPeerOe_n ? addressStrobePeer_n : 1'b1);
    modport dev (
        output addrDev, addrDevOe_n, transferByteCountDev, transactionCodeLinesDev,
        output transferStartDev_n, addressStrobeDev_n,
        input addr, transferByteCount, transactionCodeLines, transferStart_n, addressStrobe_n,
        input dmaAcknowledge_n
    );
    modport peer (
        output addrPeer, addrPeerOe_n, transferByteCountPeer, transactionCodeLinesPeer,
        output transferStartPeer_n, addressStrobePeer_n, dmaAcknowledge_n,
        input addr, transferByteCount, transactionCodeLines, transferStart_n, addressStrobe_n
    );
endinterface // lbac_if

// >>> lbac_dev.sv
// lbac_dev: bridge end of the local bus address cycle (master and slave)
// Behaviour
// - size lines give byte count, select lanes
// - code lines driven only as master
// - slave captures code on falling edge after strobe; here on the rising edge one cycle after the synchronised strobe fall is seen
// - dma transfers use all-ones code
// - code lines share address timing
// - master code equals target image field
// - address driven as master, input otherwise
// - slave samples address with transfer start
// - new address launched after rising edge
// - register offset uses low twelve bits
`timescale 1ns/10ps
module lbac_dev (
    input wire logic mclk,
    input wire logic rst_n,
    lbac_if.dev bus,
    input wire logic mstGrant,
    input wire logic mstStart,
    input wire logic [31:0] mstAddr,
    input wire logic [1:0] mstSize,
    input wire logic [3:0] imageCode,
    input wire logic mstEnd,
    output logic mstOwner,
    output logic slvValid,
    output logic [31:0] slvAddr,
    output logic [1:0] slvSize,
    output logic [11:0] slvRegOff,
    output logic [3:0] slvCode,
    output logic slvCodeValid,
    output logic slvDma,
    output logic [3:0] slvLaneMask
);
    ////////////////////////////////////////////////////////////
    // input synchronisers: pins cross into mclk through two flops
    logic [31:0] addrMeta_reg, addrSync_reg;
    logic [1:0] sizeMeta_reg, sizeSync_reg;
    logic [3:0] codeMeta_reg, codeSync_reg;
    logic tsMeta_reg, tsSync_reg, asMeta_reg, asSync_reg, dackMeta_reg, dackSync_reg;
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            addrMeta_reg <= lbac_pkg::ADDR_RST;
            addrSync_reg <= lbac_pkg::ADDR_RST;
            sizeMeta_reg <= lbac_pkg::SIZE_RST;
            sizeSync_reg <= lbac_pkg::SIZE_RST;
            codeMeta_reg <= lbac_pkg::CODE_RST;
            codeSync_reg <= lbac_pkg::CODE_RST;
            tsMeta_reg <= 1'b1;
            tsSync_reg <= 1'b1;
            asMeta_reg <= 1'b1;
            asSync_reg <= 1'b1;
            dackMeta_reg <= 1'b1;
            dackSync_reg <= 1'b1;
        end else begin
            addrMeta_reg <= bus.addr;
            addrSync_reg <= addrMeta_reg;
            sizeMeta_reg <= bus.transferByteCount;
            sizeSync_reg <= sizeMeta_reg;
            codeMeta_reg <= bus.transactionCodeLines;
            codeSync_reg <= codeMeta_reg;
            tsMeta_reg <= bus.transferStart_n;
            tsSync_reg <= tsMeta_reg;
            asMeta_reg <= bus.addressStrobe_n;
            asSync_reg <= asMeta_reg;
            dackMeta_reg <= bus.dmaAcknowledge_n;
            dackSync_reg <= dackMeta_reg;
        end
    end

    ////////////////////////////////////////////////////////////
    // lane mask from size and low address, 32-bit port, big-endian lanes
    function automatic logic [3:0] laneMask(input logic [1:0] siz, input logic [1:0] a);
        logic [3:0] m;
        m = 4'h0;
        unique case (siz)
            lbac_pkg::SIZE_BYTE: m = 4'h8 >> a;
            lbac_pkg::SIZE_HALF: m = a[1] ? 4'h3 : 4'hc;
            lbac_pkg::SIZE_TRI: m = a[0] ? 4'h7 : 4'he;
            lbac_pkg::SIZE_LONG: m = 4'hf;
        endcase
        return m;
    endfunction

    ////////////////////////////////////////////////////////////
    // master side: ownership and launch
    logic [31:0] addrOut_reg;
    logic [1:0] sizeOut_reg;
    logic [3:0] codeOut_reg;
    logic tsOut_reg;
    logic owner_reg;
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            owner_reg <= 1'b0;
        end else if (mstEnd) begin
            owner_reg <= 1'b0;
        end else if (mstGrant) begin
            owner_reg <= 1'b1;
        end
    end
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            addrOut_reg <= lbac_pkg::ADDR_RST;
            sizeOut_reg <= lbac_pkg::SIZE_RST;
            codeOut_reg <= lbac_pkg::CODE_RST;
            tsOut_reg <= 1'b1;
        end else begin
            // a start in the releasing cycle would strobe a floating bus
            tsOut_reg <= !(owner_reg && mstStart && !mstEnd);
            if (owner_reg && mstStart && !mstEnd) begin
                addrOut_reg <= mstAddr;
                sizeOut_reg <= mstSize;
                codeOut_reg <= imageCode;
            end
        end
    end
    assign bus.addrDevOe_n = !owner_reg;
    assign bus.addrDev = addrOut_reg;
    assign bus.transferByteCountDev = sizeOut_reg;
    assign bus.transactionCodeLinesDev = codeOut_reg;
    assign bus.transferStartDev_n = tsOut_reg;
    assign bus.addressStrobeDev_n = tsOut_reg;
    assign mstOwner = owner_reg;

    ////////////////////////////////////////////////////////////
    // slave side: address qualify and code capture
    logic slvValid_reg, codeValid_reg, dma_reg, asPrev_reg, codePend_reg, dackPend_reg;
    logic [31:0] slvAddr_reg;
    logic [1:0] slvSize_reg;
    logic [3:0] slvCode_reg, lane_reg;
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            slvValid_reg <= 1'b0;
            slvAddr_reg <= lbac_pkg::ADDR_RST;
            slvSize_reg <= lbac_pkg::SIZE_RST;
            lane_reg <= 4'h0;
        end else begin
            slvValid_reg <= !owner_reg && !tsSync_reg;
            if (!owner_reg && !tsSync_reg) begin
                slvAddr_reg <= addrSync_reg;
                slvSize_reg <= sizeSync_reg;
                lane_reg <= laneMask(sizeSync_reg, addrSync_reg[1:0]);
            end
        end
    end
    // capture after strobe, next falling edge equivalent
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            asPrev_reg <= 1'b1;
            codePend_reg <= 1'b0;
            codeValid_reg <= 1'b0;
            slvCode_reg <= lbac_pkg::CODE_RST;
            dma_reg <= 1'b0;
            dackPend_reg <= 1'b0;
        end else begin
            asPrev_reg <= asSync_reg;
            // acknowledge lasts one cycle, so keep it until the capture
            dackPend_reg <= !dackSync_reg;
            codePend_reg <= !owner_reg && asPrev_reg && !asSync_reg;
            codeValid_reg <= codePend_reg;
            if (codePend_reg) begin
                slvCode_reg <= codeSync_reg;
                dma_reg <= dackPend_reg && (codeSync_reg == lbac_pkg::CODE_DMA);
            end
        end
    end
    assign slvValid = slvValid_reg;
    assign slvAddr = slvAddr_reg;
    assign slvSize = slvSize_reg;
    assign slvRegOff = slvAddr_reg[lbac_pkg::REG_OFF_W-1:0];
    assign slvCode = slvCode_reg;
    assign slvCodeValid = codeValid_reg;
    assign slvDma = dma_reg;
    assign slvLaneMask = lane_reg;
endmodule // lbac_dev

// >>> lbac_peer.sv
// lbac_peer: external local bus master/slave facing the bridge
`timescale 1ns/10ps
module lbac_peer (
    input wire logic mclk,
    input wire logic rst_n,
    lbac_if.peer bus,
    input wire logic reqOwn,
    input wire logic reqStart,
    input wire logic [31:0] reqAddr,
    input wire logic [1:0] reqSize,
    input wire logic [3:0] reqCode,
    input wire logic reqDma,
    output logic peerOwner,
    output logic seenValid,
    output logic [31:0] seenAddr,
    output logic [1:0] seenSize,
    output logic [3:0] seenCode
);
    logic own_reg, ts_reg, dack_reg;
    logic [31:0] addr_reg;
    logic [1:0] size_reg;
    logic [3:0] code_reg;
    ////////////////////////////////////////////////////////////
    // peer drives address when owning
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            own_reg <= 1'b0;
            ts_reg <= 1'b1;
            dack_reg <= 1'b1;
            addr_reg <= lbac_pkg::ADDR_RST;
            size_reg <= lbac_pkg::SIZE_RST;
            code_reg <= lbac_pkg::CODE_RST;
        end else begin
            own_reg <= reqOwn;
            ts_reg <= !(reqOwn && reqStart);
            dack_reg <= !(reqOwn && reqStart && reqDma);
            if (reqOwn && reqStart) begin
                addr_reg <= reqAddr;
                size_reg <= reqSize;
                code_reg <= reqDma ? lbac_pkg::CODE_DMA : reqCode;
            end
        end
    end
    assign bus.addrPeerOe_n = !own_reg;
    assign bus.addrPeer = addr_reg;
    assign bus.transferByteCountPeer = size_reg;
    assign bus.transactionCodeLinesPeer = code_reg;
    assign bus.transferStartPeer_n = ts_reg;
    assign bus.addressStrobePeer_n = ts_reg;
    assign bus.dmaAcknowledge_n = dack_reg;
    assign peerOwner = own_reg;
    ////////////////////////////////////////////////////////////
    // observe bridge-mastered cycles; same clock, no synchroniser needed
    logic v_reg;
    logic [31:0] sa_reg;
    logic [1:0] ss_reg;
    logic [3:0] sc_reg;
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            v_reg <= 1'b0;
            sa_reg <= lbac_pkg::ADDR_RST;
            ss_reg <= lbac_pkg::SIZE_RST;
            sc_reg <= lbac_pkg::CODE_RST;
        end else begin
            v_reg <= !own_reg && !bus.transferStart_n;
            if (!own_reg && !bus.transferStart_n) begin
                sa_reg <= bus.addr;
                ss_reg <= bus.transferByteCount;
                sc_reg <= bus.transactionCodeLines;
            end
        end
    end
    assign seenValid = v_reg;
    assign seenAddr = sa_reg;
    assign seenSize = ss_reg;
    assign seenCode = sc_reg;
endmodule // lbac_peer

// >>> lbac_chk.sv
// lbac_chk: interface-level assertions for the local bus address cycle
`timescale 1ns/10ps
module lbac_chk (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic [31:0] addrDev,
    input wire logic addrDevOe_n,
    input wire logic addrPeerOe_n,
    input wire logic [1:0] transferByteCountDev,
    input wire logic [3:0] transactionCodeLinesDev,
    input wire logic [3:0] transactionCodeLines,
    input wire logic transferStartDev_n,
    input wire logic transferStartPeer_n,
    input wire logic dmaAcknowledge_n
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    ////////////////////////////////////////////////////////////////
    property p_addr_launch;
        !addrDevOe_n && !$past(addrDevOe_n) && $changed(addrDev) |-> !transferStartDev_n;
    endproperty
    a_addr_launch: assert property (p_addr_launch) else $error("address moved without start");
    property p_code_timing;
        !addrDevOe_n && !$past(addrDevOe_n) && $changed(transactionCodeLinesDev) |-> !transferStartDev_n;
    endproperty
    a_code_timing: assert property (p_code_timing) else $error("code moved off address timing");
    property p_size_timing;
        !addrDevOe_n && !$past(addrDevOe_n) && $changed(transferByteCountDev) |-> !transferStartDev_n;
    endproperty
    a_size_timing: assert property (p_size_timing) else $error("size moved off address timing");
    property p_strobe_owner;
        !transferStartDev_n |-> !addrDevOe_n;
    endproperty
    a_strobe_owner: assert property (p_strobe_owner) else $error("start strobe without ownership");
    property p_exclusive;
        !addrDevOe_n |-> addrPeerOe_n;
    endproperty
    a_exclusive: assert property (p_exclusive) else $error("both ends drive the bus");
    property p_float;
        addrDevOe_n && addrPeerOe_n |-> transactionCodeLines == 4'hf;
    endproperty
    a_float: assert property (p_float) else $error("code lines not released");
    property p_dma_code;
        !dmaAcknowledge_n |-> transactionCodeLines == 4'hf;
    endproperty
    a_dma_code: assert property (p_dma_code) else $error("dma cycle without all-ones code");
    property p_dma_pulse;
        $fell(dmaAcknowledge_n) |=> dmaAcknowledge_n;
    endproperty
    a_dma_pulse: assert property (p_dma_pulse) else $error("dma acknowledge too long");
    // one-cycle strobe keeps a stale address from being taken twice
    property p_peer_start;
        $fell(transferStartPeer_n) |=> transferStartPeer_n;
    endproperty
    a_peer_start: assert property (p_peer_start) else $error("peer start strobe too long");
endmodule // lbac_chk

// >>> local_bus_address_cycle_pins_tb.sv
// local_bus_address_cycle_pins_tb: both ends joined and judged from their user sides and the resolved bus wires
`timescale 1ns/10ps
module local_bus_address_cycle_pins_tb;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic mstGrant = 1'b0, mstStart = 1'b0, mstEnd = 1'b0, reqOwn = 1'b0, reqStart = 1'b0, reqDma = 1'b0;
    logic [31:0] mstAddr = 32'h0, reqAddr = 32'h0, slvAddr, seenAddr;
    logic [1:0] mstSize = 2'h0, reqSize = 2'h0, slvSize, seenSize;
    logic [3:0] imageCode = 4'h0, reqCode = 4'h0, slvCode, slvLaneMask, seenCode;
    logic [11:0] slvRegOff;
    logic mstOwner, slvValid, slvCodeValid, slvDma, peerOwner, seenValid;
    int errorCnt = 0;
    int testsRun = 0;
    // lanes big-endian, size 0 means four bytes
    logic [31:0] tAddr [5] = '{32'habcd_e120, 32'h1234_5003, 32'hfedc_b002, 32'h0000_0ff1, 32'h5555_a120};
    logic [3:0] tCode [5] = '{4'h5, 4'ha, 4'h3, 4'hc, 4'h0};
    logic [3:0] tLane [5] = '{4'hf, 4'h1, 4'h3, 4'h7, 4'hf};
    lbac_if bus ();
    lbac_dev lbac_dev_inst (.mclk, .rst_n, .bus(bus.dev), .mstGrant, .mstStart, .mstAddr, .mstSize, .imageCode,
        .mstEnd, .mstOwner, .slvValid, .slvAddr, .slvSize, .slvRegOff, .slvCode, .slvCodeValid, .slvDma,
        .slvLaneMask);
    lbac_peer lbac_peer_inst (.mclk, .rst_n, .bus(bus.peer), .reqOwn, .reqStart, .reqAddr, .reqSize, .reqCode,
        .reqDma, .peerOwner, .seenValid, .seenAddr, .seenSize, .seenCode);
    lbac_chk lbac_chk_inst (.mclk, .rst_n, .addrDev(bus.addrDev), .addrDevOe_n(bus.addrDevOe_n),
        .addrPeerOe_n(bus.addrPeerOe_n), .transferByteCountDev(bus.transferByteCountDev),
        .transactionCodeLinesDev(bus.transactionCodeLinesDev), .transactionCodeLines(bus.transactionCodeLines),
        .transferStartDev_n(bus.transferStartDev_n), .transferStartPeer_n(bus.transferStartPeer_n),
        .dmaAcknowledge_n(bus.dmaAcknowledge_n));
    ////////////////////////////////////////////////////////////////
    task automatic chk(input string what, input logic [31:0] expv, input logic [31:0] got);
        testsRun++;
        if (got !== expv) begin
            errorCnt++;
            $display("wrong value %s expected %h seen %h", what, expv, got);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    // bounded wait; a missing pulse shows up as a mismatch
    task automatic waitHigh(ref logic flag, input string what);
        int n;
        n = 0;
        while (flag !== 1'b1 && n < 12) begin
            step(1);
            n++;
        end
        chk(what, 32'h1, {31'h0, flag});
    endtask
    task automatic endOfTest;
        if (errorCnt == 0 && testsRun > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////
    task automatic masterStart(input int i);
        mstStart = 1'b1;
        mstAddr = tAddr[i];
        mstSize = 2'(i);
        imageCode = tCode[i];
        step(1);
        chk("addr", tAddr[i], bus.addr);
        chk("size", 32'(i), {30'h0, bus.transferByteCount});
        chk("code", {28'h0, tCode[i]}, {28'h0, bus.transactionCodeLines});
        chk("strobe", 32'h0, {31'h0, bus.transferStart_n});
    endtask
    task automatic masterCycles;
        mstStart = 1'b1;
        step(1);
        chk("refused strobe", 32'h1, {31'h0, bus.transferStartDev_n});
        mstStart = 1'b0;
        step(1);
        mstGrant = 1'b1;
        step(1);
        chk("owner", 32'h1, {31'h0, mstOwner});
        for (int i = 0; i < 3; i++) begin
            masterStart(i);
        end
        mstStart = 1'b0;
        step(6);
        masterStart(3);
        mstStart = 1'b0;
        waitHigh(seenValid, "seen valid");
        chk("seen addr", tAddr[3], seenAddr);
        chk("seen size", 32'h3, {30'h0, seenSize});
        chk("seen code", {28'h0, tCode[3]}, {28'h0, seenCode});
        mstEnd = 1'b1;
        mstGrant = 1'b0;
        step(1);
        mstEnd = 1'b0;
        step(1);
        chk("released code", 32'hf, {28'h0, bus.transactionCodeLines});
    endtask
    task automatic slaveCycles;
        reqOwn = 1'b1;
        step(2);
        chk("peer owner", 32'h1, {31'h0, peerOwner});
        for (int i = 0; i < 5; i++) begin
            reqStart = 1'b1;
            reqAddr = tAddr[i];
            reqSize = 2'(i % 4);
            reqCode = tCode[i];
            reqDma = (i == 4);
            step(1);
            reqStart = 1'b0;
            reqDma = 1'b0;
            waitHigh(slvValid, "slave valid");
            chk("slave addr", tAddr[i], slvAddr);
            chk("slave size", 32'(i % 4), {30'h0, slvSize});
            chk("reg offset", {20'h0, tAddr[i][11:0]}, {20'h0, slvRegOff});
            chk("lanes", {28'h0, tLane[i]}, {28'h0, slvLaneMask});
            waitHigh(slvCodeValid, "code valid");
            chk("slave code", (i == 4) ? 32'hf : {28'h0, tCode[i]}, {28'h0, slvCode});
            chk("dma", 32'(i == 4), {31'h0, slvDma});
            step(2);
        end
        reqOwn = 1'b0;
        step(2);
        chk("peer released", 32'h0, {31'h0, peerOwner});
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        forever #2.5 mclk = ~mclk;
    end
    initial begin
        #(5 * 5000);
        errorCnt++;
        endOfTest();
    end
    initial begin
        step(10);
        rst_n = 1'b1;
        masterCycles();
        slaveCycles();
        endOfTest();
    end
endmodule // local_bus_address_cycle_pins_tb
